// file: pkg/port6_params.svh
// offsets, field positions, reset values and widths for the bus control port
`ifndef PORT6_PARAMS_SVH
`define PORT6_PARAMS_SVH
`define OFF_PIN_DIRECTION 16'hFFC9
`define OFF_PIN_OUTPUT_LATCH 16'hFFCB
`define OFF_BUS_CFG 16'hFFD0
`define RST_PIN_DIRECTION 8'h80
`define RST_PIN_OUTPUT_LATCH 8'h80
`define RST_BUS_CFG 32'h0000_00FF
`define BIT_RESERVED 7
`define BIT_LOWER_WRITE 6
`define BIT_UPPER_WRITE 5
`define BIT_READ 4
`define BIT_ADDR_STROBE 3
`define BIT_BUS_ACK 2
`define BIT_BUS_REQ 1
`define BIT_WAIT 0
`define CFG_WAIT_EN_LSB 0
`define CFG_WAIT_EN_MSB 7
`define CFG_BUS_RELEASE 8
`define CFG_WAIT_MODE1 9
`define CFG_DRAM_AREA3 10
`define CFG_SW_STANDBY 11
`define CFG_HW_STANDBY 12
`define PORT_PINS 7
`endif

// file: pkg/port6_pkg.sv
// types shared by the bus control port design
package port6_pkg;
  typedef enum logic [1:0] {apb_idle, apb_setup, apb_access} apb_phase_e;
  typedef logic [2:0] mode_t;
  typedef logic [6:0] pins_t;
endpackage

// file: src/port6_apb_slave.sv
// apb slave front end: decode, strobes and read mux for the port registers
`timescale 1ns/1ns
`default_nettype none
`include "port6_params.svh"
module port6_apb_slave (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [31:0] rd_dir, // read value of direction reg
  input wire logic [31:0] rd_latch, // read value of latch reg
  input wire logic [31:0] rd_cfg, // read value of config reg
  output logic wr_dir, // write strobe direction
  output logic wr_latch, // write strobe latch
  output logic wr_cfg, // write strobe config
  output logic [31:0] wdata // write data to registers
);
  wire logic hit_dir;
  wire logic hit_latch;
  wire logic hit_cfg;
  wire logic mapped;
  wire logic access;
  wire logic [31:0] next_prdata;
  // port offsets are odd, so they are word indices: byte address is four times the index
  // the two indices would collide if shifted down, so match the index itself
  assign hit_dir = paddr[15:2] == 14'(`OFF_PIN_DIRECTION);
  assign hit_latch = paddr[15:2] == 14'(`OFF_PIN_OUTPUT_LATCH);
  assign hit_cfg = paddr[15:2] == 14'(`OFF_BUS_CFG >> 2);
  assign mapped = hit_dir | hit_latch | hit_cfg;
  assign access = psel & penable;
  assign pready = access;
  assign pslverr = access & ~mapped;
  assign wr_dir = access & pwrite & hit_dir;
  assign wr_latch = access & pwrite & hit_latch;
  assign wr_cfg = access & pwrite & hit_cfg;
  assign wdata = pwdata;
  assign next_prdata = hit_dir ? rd_dir : hit_latch ? rd_latch : hit_cfg ? rd_cfg : 32'h0;
  // read data sampled in setup so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// file: src/port6_pin_mux.sv
// per-pin function select between bus strobes, handshakes and plain i/o
`timescale 1ns/1ns
`default_nettype none
`include "port6_params.svh"
module port6_pin_mux
  import port6_pkg::*;
(
  input wire logic expanded, // modes 1 to 6
  input wire port6_pkg::pins_t dir, // direction bits
  input wire port6_pkg::pins_t latch, // latch bits
  input wire logic bus_release, // bus release enable
  input wire logic wait_pin_sel, // pin 0 is wait input
  input wire logic strobe_lwr, // lower write strobe level
  input wire logic strobe_hwr, // upper write strobe level
  input wire logic strobe_rd, // read strobe level
  input wire logic strobe_as, // address strobe level
  input wire logic bus_ack, // bus acknowledge level
  output port6_pkg::pins_t pin_out, // pin drive value
  output port6_pkg::pins_t pin_oe_n, // pin enable, low drives
  output port6_pkg::pins_t gp_input // pin reads as input
);
  wire pins_t bus_drive;
  wire pins_t bus_value;
  wire pins_t bus_input;
  // in expanded modes the top four pins are strobes regardless of dir
  assign bus_drive = expanded ? {4'hF, bus_release, 2'h0} : 7'h00;
  assign bus_value = {strobe_lwr, strobe_hwr, strobe_rd, strobe_as, bus_ack, 2'h0};
  // handshake inputs force the pin to input
  assign bus_input = expanded ? {5'h00, bus_release, wait_pin_sel} : 7'h00;
  assign pin_out = (bus_drive & bus_value) | (~bus_drive & latch);
  // general pins follow dir in both modes
  assign pin_oe_n = ~(bus_drive | (dir & ~bus_input & ~bus_drive));
  assign gp_input = ~dir;
endmodule
`default_nettype wire

// file: src/port6_bus_port.sv
// seven-bit i/o port shared with external bus control signals
// Function
// - in mode 7 each pin is an output when its direction bit is 1 and an input when 0.
// - in modes 1 to 6 pins 6 to 3 always drive lower write, upper write, read and address strobe.
// - in expanded modes pins 2 to 0 are general i/o under direction unless a handshake claims them.
// - with dram in area 3 the lower and upper write strobe pins also carry the dram byte write and column strobes.
// - the direction register is write-only, reads all ones, and bit 7 is reserved.
// - reset and hardware standby load the direction register with 80 hex.
// - in software standby the direction register holds and output pins keep driving.
// - a data read gives pin level where direction is 0 and the latch where direction is 1.
// - data bit 7 is reserved, ignores writes and reads as one.
// - reset and hardware standby set the latch to 80 hex, software standby keeps it.
// - in modes 1 to 6 with bus release enabled pin 2 outputs bus acknowledge and pin 1 inputs bus request.
// - in modes 1 to 6 pin 0 is the wait input when wait enables are not all ones or wait mode bit 1 is set.
// - modes 1 to 6 are expanded with an external bus, mode 7 is single chip.
`timescale 1ns/1ns
`default_nettype none
`include "port6_params.svh"
module port6_bus_port
  import port6_pkg::*;
#(
  parameter int PINS = `PORT_PINS // port width
) (
  input wire logic pclk, // system clock, 250 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire port6_pkg::mode_t mode, // operating mode 1 to 7
  input wire logic strobe_lwr, // lower write strobe from bus controller
  input wire logic strobe_hwr, // upper write strobe from bus controller
  input wire logic strobe_rd, // read strobe from bus controller
  input wire logic strobe_as, // address strobe from bus controller
  input wire logic bus_ack, // bus acknowledge from bus controller
  input wire logic [PINS-1:0] pin_in, // pin levels
  output logic [PINS-1:0] pin_out, // pin drive values
  output logic [PINS-1:0] pin_oe_n, // pin enable, low drives
  output logic bus_request_in, // bus request seen on pin 1
  output logic wait_in, // wait seen on pin 0
  output logic bus_release_enable, // bus release enable bit
  output logic dram_low_byte_write, // dram lower byte write strobe
  output logic dram_high_byte_write, // dram upper byte write strobe
  output logic dram_lower_col_strobe, // dram lower column strobe
  output logic dram_upper_col_strobe // dram upper column strobe
);
  import port6_pkg::*;

  logic [7:0] pin_direction;
  logic [7:0] pin_output_latch;
  logic [12:0] bus_cfg;
  wire logic wr_dir;
  wire logic wr_latch;
  wire logic wr_cfg;
  wire logic [31:0] wdata;
  wire logic [31:0] rd_dir;
  wire logic [31:0] rd_latch;
  wire logic [31:0] rd_cfg;
  wire logic expanded;
  wire logic hw_standby;
  wire logic sw_standby;
  wire logic dram_area3;
  wire logic wait_pin_sel;
  wire logic [7:0] wait_enable_reg;
  wire logic wait_mode_bit1;
  wire logic hold;
  wire logic [7:0] next_pin_direction;
  wire logic [7:0] next_pin_output_latch;
  wire pins_t gp_input;
  wire pins_t mux_out;
  wire pins_t mux_oe_n;
  wire pins_t read_mix;

  // reinit wins over a write; reserved bit 7 is forced to one on every write
  function automatic logic [7:0] next_port_reg(input logic reinit, input logic wr,
                                               input logic [6:0] wd, input logic [7:0] cur,
                                               input logic [7:0] rst);
    next_port_reg = reinit ? rst : wr ? {1'b1, wd} : cur;
  endfunction

  // park an input or strobe inactive high while its function is not claimed
  function automatic logic pass_or_idle(input logic claim, input logic level);
    pass_or_idle = claim ? level : 1'b1;
  endfunction

  assign expanded = (mode != 3'h7) && (mode != 3'h0);
  assign wait_enable_reg = bus_cfg[`CFG_WAIT_EN_MSB:`CFG_WAIT_EN_LSB];
  assign bus_release_enable = bus_cfg[`CFG_BUS_RELEASE];
  assign wait_mode_bit1 = bus_cfg[`CFG_WAIT_MODE1];
  assign dram_area3 = bus_cfg[`CFG_DRAM_AREA3];
  assign sw_standby = bus_cfg[`CFG_SW_STANDBY];
  assign hw_standby = bus_cfg[`CFG_HW_STANDBY];
  // wait claims pin 0 only when the wait function is active
  assign wait_pin_sel = (wait_enable_reg != 8'hFF) | wait_mode_bit1;

  // software standby freezes port state; hardware standby reinitialises
  assign hold = sw_standby & ~hw_standby;
  assign next_pin_direction = next_port_reg(hw_standby, wr_dir & ~hold, wdata[6:0],
                                            pin_direction, `RST_PIN_DIRECTION);
  assign next_pin_output_latch = next_port_reg(hw_standby, wr_latch & ~hold, wdata[6:0],
                                               pin_output_latch,
                                               `RST_PIN_OUTPUT_LATCH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction <= `RST_PIN_DIRECTION;
      pin_output_latch <= `RST_PIN_OUTPUT_LATCH;
    end else begin
      pin_direction <= next_pin_direction;
      pin_output_latch <= next_pin_output_latch;
    end
  end

  // standby bits stay writable so software can leave standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_cfg <= 13'(`RST_BUS_CFG);
    end else if (wr_cfg) begin
      bus_cfg <= wdata[12:0];
    end
  end

  assign rd_dir = {24'h0, 8'hFF};
  assign read_mix = (gp_input & pin_in) | (~gp_input & pin_output_latch[6:0]);
  assign rd_latch = {24'h0, 1'b1, read_mix};
  assign rd_cfg = {19'h0, bus_cfg};

  port6_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rd_dir(rd_dir),
    .rd_latch(rd_latch),
    .rd_cfg(rd_cfg),
    .wr_dir(wr_dir),
    .wr_latch(wr_latch),
    .wr_cfg(wr_cfg),
    .wdata(wdata)
  );

  port6_pin_mux u_mux (
    .expanded(expanded),
    .dir(pin_direction[6:0]),
    .latch(pin_output_latch[6:0]),
    .bus_release(bus_release_enable),
    .wait_pin_sel(wait_pin_sel),
    .strobe_lwr(strobe_lwr),
    .strobe_hwr(strobe_hwr),
    .strobe_rd(strobe_rd),
    .strobe_as(strobe_as),
    .bus_ack(bus_ack),
    .pin_out(mux_out),
    .pin_oe_n(mux_oe_n),
    .gp_input(gp_input)
  );

  assign pin_out = mux_out;
  assign pin_oe_n = mux_oe_n;
  // handshake inputs read as inactive high when not claimed
  assign bus_request_in = pass_or_idle(expanded & bus_release_enable,
                                       pin_in[`BIT_BUS_REQ]);
  assign wait_in = pass_or_idle(expanded & wait_pin_sel, pin_in[`BIT_WAIT]);
  // dram strobes share the lower and upper write strobe pins; inactive high otherwise
  assign dram_low_byte_write = pass_or_idle(expanded & dram_area3, strobe_lwr);
  assign dram_high_byte_write = pass_or_idle(expanded & dram_area3, strobe_hwr);
  assign dram_lower_col_strobe = pass_or_idle(expanded & dram_area3, strobe_lwr);
  assign dram_upper_col_strobe = pass_or_idle(expanded & dram_area3, strobe_hwr);
endmodule
`default_nettype wire

// file: verification/port6_bus_partner.sv
// far side model: bus devices on the shared pins
`timescale 1ns/1ns
`default_nettype none
module port6_bus_partner (
  input wire logic [6:0] pin_out, // port drive
  input wire logic [6:0] pin_oe_n, // low drives
  input wire logic [6:0] ext_drive, // far levels
  output logic [6:0] pin_in // wire levels
);
  // far side drives only free pins, so a claimed wait pin stays an input
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule
`default_nettype wire

// file: verification/port6_bus_port_assertions.sv
// assertion checker for the bus control port
`timescale 1ns/1ns
`default_nettype none
module port6_bus_port_assertions #(parameter int PINS = 7) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pready, // ready
  input wire port6_pkg::mode_t mode, // mode
  input wire logic strobe_lwr, // strobe
  input wire logic bus_ack, // ack
  input wire logic [PINS-1:0] pin_in, // level
  input wire logic [PINS-1:0] pin_out, // drive
  input wire logic [PINS-1:0] pin_oe_n, // enable
  input wire logic bus_request_in, // request
  input wire logic wait_in, // wait
  input wire logic bus_release_enable, // release
  input wire logic dram_low_byte_write // dram
);
  import port6_pkg::*;
  wire logic expd;
  assign expd = mode != 3'h0 && mode != 3'h7;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_lower_write_pin: assert property (expd |-> !pin_oe_n[6] && pin_out[6] == strobe_lwr)
    else $error("pin 6 wrong");
  a_release_ack_pin: assert property (expd && bus_release_enable |-> !pin_oe_n[2]
    && pin_out[2] == bus_ack) else $error("pin 2 wrong");
  a_release_req_in: assert property (expd && bus_release_enable |-> pin_oe_n[1]
    && bus_request_in == pin_in[1]) else $error("pin 1 wrong");
  a_idle_req_high: assert property (!bus_release_enable |-> bus_request_in)
    else $error("request wrong");
  a_wait_from_pin: assert property (!wait_in |-> expd && pin_oe_n[0] && !pin_in[0])
    else $error("wait wrong");
  a_dram_copy: assert property (!dram_low_byte_write |-> expd && !strobe_lwr)
    else $error("dram strobe wrong");
  a_ready_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("no ready");
  a_reset_inputs: assert property ($rose(presetn) && mode == 3'h7 |-> &pin_oe_n)
    else $error("pins driven");
  c_expanded: cover property (expd && !pin_oe_n[6]);
  c_release: cover property (expd && bus_release_enable);
  c_wait: cover property (!wait_in);
endmodule
bind port6_bus_port port6_bus_port_assertions #(.PINS(PINS)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .mode(mode), .strobe_lwr(strobe_lwr), .bus_ack(bus_ack), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .bus_request_in(bus_request_in),
  .wait_in(wait_in), .bus_release_enable(bus_release_enable),
  .dram_low_byte_write(dram_low_byte_write));
`default_nettype wire

// file: verification/test_seven_bit_bus_control_port.sv
// self-checking bench for the bus control port
`timescale 1ns/1ns
`default_nettype none
module test_seven_bit_bus_control_port;
  import port6_pkg::*;
  localparam logic [15:0] idx_dir = 16'hFFC9, idx_lat = 16'hFFCB, adr_cfg = 16'hFFD0;
  localparam logic [15:0] adr_dir = {idx_dir[13:0], 2'h0}, adr_lat = {idx_lat[13:0], 2'h0};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, last_err;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, bus_request_in, wait_in, bus_release_enable;
  mode_t mode = 3'h7;
  logic strobe_lwr = 1'h0, strobe_hwr = 1'h1, strobe_rd = 1'h0, strobe_as = 1'h1, bus_ack = 1'h0;
  logic [6:0] pin_in, pin_out, pin_oe_n, ext_drive = 7'h55;
  wire logic [3:0] dram;
  int fails = 0, check_count = 0, cyc = 0;
  always #2 pclk = ~pclk;
  port6_bus_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode(mode), .strobe_lwr(strobe_lwr), .strobe_hwr(strobe_hwr),
    .strobe_rd(strobe_rd), .strobe_as(strobe_as), .bus_ack(bus_ack), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .bus_request_in(bus_request_in),
    .wait_in(wait_in), .bus_release_enable(bus_release_enable),
    .dram_low_byte_write(dram[3]), .dram_high_byte_write(dram[2]),
    .dram_lower_col_strobe(dram[1]), .dram_upper_col_strobe(dram[0]));
  port6_bus_partner far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext_drive),
    .pin_in(pin_in));
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, wd};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {d, last_err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(negedge pclk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    fails += int'(cyc >= 1000);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) report_and_stop;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, adr_dir, 32'h0);
    check(d, 32'hFF);
    apb(1'h1, adr_lat, 32'h2A);
    apb(1'h1, adr_dir, 32'h7F);
    check({18'h0, pin_oe_n, pin_out}, 32'h2A);
    apb(1'h1, adr_dir, 32'h0F);
    apb(1'h0, adr_lat, 32'h0);
    check(d, 32'hDA);
    // standby writes must bounce off both registers
    apb(1'h1, adr_cfg, 32'h8FF);
    apb(1'h1, adr_dir, 32'h0);
    apb(1'h1, adr_lat, 32'h0);
    check({21'h0, pin_oe_n, pin_out[3:0]}, 32'h70A);
    apb(1'h1, adr_cfg, 32'h10FF);
    apb(1'h1, adr_cfg, 32'hFF);
    check({25'h0, pin_oe_n}, 32'h7F);
    apb(1'h1, adr_dir, 32'h7F);
    check({25'h0, pin_out}, 32'h0);
    for (int m = 1; m < 7; m++) begin
      @(posedge pclk);
      mode <= 3'(m);
      ext_drive <= 7'h56;
      bus_ack <= 1'h1;
      @(negedge pclk);
      check({18'h0, pin_oe_n, pin_out}, 32'h28);
    end
    apb(1'h1, adr_cfg, 32'h1FF);
    check({27'h0, bus_request_in, bus_release_enable, pin_oe_n[2:1], pin_out[2]}, 32'h1B);
    apb(1'h1, adr_dir, 32'h7E);
    apb(1'h1, adr_cfg, 32'h4FE);
    check({26'h0, wait_in, pin_oe_n[0], dram}, 32'h15);
    apb(1'h0, 16'h0100, 32'h0);
    check({last_err, d[30:0]}, 32'h80000000);
    report_and_stop;
  end
endmodule
`default_nettype wire
